// >>> rtl/i2c_master_bus_sequencer.sv
// Purpose: Master sequencer: repeated start, acknowledge, stop, byte send.
// Assumes: SCL and SDA pins are open drain, sampled through two flops.
// Notes: First start and master reception are outside this block.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.

//---------------------------------------------------------------------
// Sequencer
//---------------------------------------------------------------------
module i2c_master_bus_sequencer
    import i2c_seq_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [i2c_seq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic WAKE
);
    import i2c_seq_pkg::*;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        state_e st;
        logic [7:0] baud;
        logic [7:0] cnt;
        logic [7:0] buf_q;
        logic [7:0] shreg;
        logic [3:0] bitn;
        logic en;
        logic restart_request;
        logic stop_request;
        logic ack_sequence_request;
        logic ack_value_to_send;
        logic wake_en;
        logic serial_irq_flag;
        logic bus_collision_flag;
        logic write_collision_flag;
        logic buffer_full_flag;
        logic start_seen;
        logic stop_seen;
        logic received_ack_flag;
        logic scl_low;
        logic sda_low;
        logic [7:0] rdata;
        logic wake;
    } regs_s;

    regs_s r;
    regs_s next_r;
    logic scl;
    logic sda;
    logic tick;

    //-----------------------------------------------------------------
    // Next state
    //-----------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.scl_s = {r.scl_s[0], SCL_IN};
        next_r.sda_s = {r.sda_s[0], SDA_IN};
        next_r.wake = 1'b0;
        // Second flop only; first flop feeds nothing else
        scl = r.scl_s[1];
        sda = r.sda_s[1];
        tick = (r.cnt == 8'h00);
        // Generator runs only while counting down a period
        if (r.cnt != 8'h00)
            next_r.cnt = r.cnt - 8'h01;

        // Register reads, data stand one cycle later
        next_r.rdata = 8'h00;
        if (RD)
        begin
            case (ADDR)
                REG_CTRL: next_r.rdata = {2'b00, r.wake_en,
                    r.ack_value_to_send, r.ack_sequence_request,
                    r.stop_request, r.restart_request, r.en};
                REG_STATUS: next_r.rdata = {1'b0, r.received_ack_flag,
                    r.stop_seen, r.start_seen, r.buffer_full_flag,
                    r.write_collision_flag, r.bus_collision_flag,
                    r.serial_irq_flag};
                REG_BUF: next_r.rdata = r.buf_q;
                REG_BAUD: next_r.rdata = r.baud;
                REG_RXACK: next_r.rdata = {7'h00, r.received_ack_flag};
                default: next_r.rdata = 8'h00;
            endcase
        end

        // Register writes; status flags other than BF and ACK are write one to clear
        if (WR)
        begin
            case (ADDR)
                REG_CTRL:
                begin
                    next_r.en = WDATA[CTRL_EN];
                    next_r.ack_value_to_send = WDATA[CTRL_ACKVAL];
                    next_r.wake_en = WDATA[CTRL_WAKE];
                    // Requests only while idle; no queuing of events
                    if (r.st == IDLE && r.en)
                    begin
                        next_r.restart_request = WDATA[CTRL_RESTART];
                        next_r.stop_request = WDATA[CTRL_STOP];
                        next_r.ack_sequence_request = WDATA[CTRL_ACKSEQ];
                    end
                end
                REG_STATUS:
                begin
                    if (WDATA[ST_IRQ]) next_r.serial_irq_flag = 1'b0;
                    if (WDATA[ST_BCOL]) next_r.bus_collision_flag = 1'b0;
                    if (WDATA[ST_WRITE_COLLISION_FLAG]) next_r.write_collision_flag = 1'b0;
                    if (WDATA[ST_START]) next_r.start_seen = 1'b0;
                    if (WDATA[ST_STOP]) next_r.stop_seen = 1'b0;
                end
                REG_BUF:
                begin
                    // Busy covers running sequences and pending requests
                    if (r.st != IDLE || !r.en || r.restart_request ||
                        r.stop_request || r.ack_sequence_request)
                        next_r.write_collision_flag = 1'b1;
                    else
                    begin
                        next_r.buf_q = WDATA;
                        next_r.shreg = WDATA;
                        next_r.buffer_full_flag = 1'b1;
                        next_r.bitn = 4'h0;
                        next_r.sda_low = ~WDATA[7];
                        next_r.cnt = r.baud;
                        next_r.st = TX_LOW;
                    end
                end
                REG_BAUD: next_r.baud = WDATA;
                default: ;
            endcase
        end

        // Single sequencer for every bus event
        case (r.st)
            IDLE:
            begin
                if (r.restart_request)
                begin
                    next_r.scl_low = 1'b1;
                    next_r.st = RS_LOW;
                end
                else if (r.stop_request)
                begin
                    next_r.sda_low = 1'b1;
                    next_r.st = STP_SDALO;
                end
                else if (r.ack_sequence_request)
                begin
                    next_r.scl_low = 1'b1;
                    next_r.sda_low = ~r.ack_value_to_send;
                    next_r.cnt = r.baud;
                    next_r.st = ACK_LOW;
                end
            end
            RS_LOW:
                if (!scl)
                begin
                    next_r.sda_low = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = RS_SDAHI;
                end
            RS_SDAHI:
                if (tick && sda)
                begin
                    next_r.scl_low = 1'b0;
                    next_r.st = RS_SCLHI;
                end
            RS_SCLHI:
                if (scl)
                begin
                    if (!sda)
                    begin
                        next_r.bus_collision_flag = 1'b1;
                        next_r.restart_request = 1'b0;
                        next_r.scl_low = 1'b0;
                        next_r.sda_low = 1'b0;
                        next_r.st = IDLE;
                    end
                    else
                    begin
                        next_r.cnt = r.baud;
                        next_r.st = RS_SDALO;
                    end
                end
            RS_SDALO:
                if (!scl && !r.sda_low)
                begin
                    next_r.bus_collision_flag = 1'b1;
                    next_r.restart_request = 1'b0;
                    next_r.scl_low = 1'b0;
                    next_r.st = IDLE;
                end
                else if (tick && !r.sda_low)
                begin
                    next_r.sda_low = 1'b1;
                    next_r.cnt = r.baud;
                end
                else if (tick && r.sda_low)
                begin
                    next_r.scl_low = 1'b1;
                    next_r.restart_request = 1'b0;
                    next_r.start_seen = 1'b1;
                    next_r.st = RS_END;
                end
            RS_END:
            begin
                // No reload; irq after the final timeout
                next_r.serial_irq_flag = 1'b1;
                next_r.st = IDLE;
            end
            ACK_LOW:
                if (tick)
                begin
                    next_r.scl_low = 1'b0;
                    next_r.st = ACK_HIGH;
                end
            ACK_HIGH:
                // Arbitration: count only once SCL reads high
                if (!scl)
                    next_r.cnt = r.baud;
                else if (tick && r.cnt == 8'h00 && r.scl_s[1])
                begin
                    next_r.scl_low = 1'b1;
                    next_r.ack_sequence_request = 1'b0;
                    next_r.serial_irq_flag = 1'b1;
                    next_r.st = IDLE;
                end
            STP_SDALO:
                if (!sda)
                begin
                    next_r.cnt = r.baud;
                    next_r.st = STP_SCLHI;
                end
            STP_SCLHI:
                if (tick)
                begin
                    next_r.scl_low = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = STP_SDAHI;
                end
            STP_SDAHI:
                if (!scl)
                    next_r.cnt = r.baud;
                else if (tick && !r.sda_low && sda)
                begin
                    next_r.stop_seen = 1'b1;
                    next_r.start_seen = 1'b0;
                    next_r.cnt = r.baud;
                    next_r.st = STP_DONE;
                end
                else if (tick)
                    next_r.sda_low = 1'b0;
            STP_DONE:
                if (tick)
                begin
                    next_r.stop_request = 1'b0;
                    next_r.serial_irq_flag = 1'b1;
                    next_r.st = IDLE;
                end
            TX_LOW:
                // Data changed in the same cycle as the falling edge (first bit at the buffer write), SCL low a period
                if (tick)
                begin
                    next_r.scl_low = 1'b0;
                    next_r.st = TX_HIGH;
                end
            TX_HIGH:
                if (!scl)
                    next_r.cnt = r.baud;
                else if (tick)
                begin
                    next_r.scl_low = 1'b1;
                    next_r.cnt = r.baud;
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.bitn == 4'h8)
                    begin
                        next_r.received_ack_flag = sda;
                        next_r.serial_irq_flag = 1'b1;
                        next_r.cnt = 8'h00;
                        next_r.wake = r.wake_en;
                        next_r.st = IDLE;
                    end
                    else if (r.bitn == 4'h7)
                    begin
                        next_r.buffer_full_flag = 1'b0;
                        next_r.sda_low = 1'b0;
                        next_r.st = TX_LOW;
                    end
                    else
                    begin
                        next_r.shreg = {r.shreg[6:0], 1'b0};
                        next_r.sda_low = ~r.shreg[6];
                        next_r.st = TX_LOW;
                    end
                end
            default: next_r.st = IDLE;
        endcase

        // Disabled port drops the sequence, pin pulls and requests; flags stay
        if (!next_r.en)
        begin
            next_r.st = IDLE;
            next_r.scl_low = 1'b0;
            next_r.sda_low = 1'b0;
            next_r.restart_request = 1'b0;
            next_r.stop_request = 1'b0;
            next_r.ack_sequence_request = 1'b0;
        end
    end

    //-----------------------------------------------------------------
    // State register
    //-----------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            r <= '0;
            r.baud <= BAUD_RESET;
            r.scl_s <= 2'b11;
            r.sda_s <= 2'b11;
        end
        else
            r <= next_r;
    end

    // Open drain: output always low, enable pulls the wire
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE = r.scl_low;
    assign SDA_OE = r.sda_low;
    assign RDATA = r.rdata;
    assign WAKE = r.wake;
endmodule

// >>> rtl/i2c_seq_pkg.sv
// Purpose: Shared constants for the two-wire master sequencer.
// Assumes: Single 250 MHz clock, plain register port.
// Notes: Offsets are word indices on the plain port.
package i2c_seq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_BUF = 4'h2;
    localparam logic [3:0] REG_BAUD = 4'h3;
    localparam logic [3:0] REG_RXACK = 4'h4;
    // Control bit positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_RESTART = 1;
    localparam int CTRL_STOP = 2;
    localparam int CTRL_ACKSEQ = 3;
    localparam int CTRL_ACKVAL = 4;
    localparam int CTRL_WAKE = 5;
    // Status bit positions (write one clears all but BF and ACK)
    localparam int ST_IRQ = 0;
    localparam int ST_BCOL = 1;
    localparam int ST_WRITE_COLLISION_FLAG = 2;
    localparam int ST_BF = 3;
    localparam int ST_START = 4;
    localparam int ST_STOP = 5;
    localparam int ST_ACK = 6;
    localparam logic [7:0] BAUD_RESET = 8'h09;

    typedef enum logic [3:0] {
        IDLE = 4'h0,
        RS_LOW = 4'h1,
        RS_SDAHI = 4'h2,
        RS_SCLHI = 4'h3,
        RS_SDALO = 4'h4,
        ACK_LOW = 4'h5,
        ACK_HIGH = 4'h6,
        STP_SDALO = 4'h7,
        STP_SCLHI = 4'h8,
        STP_SDAHI = 4'h9,
        STP_DONE = 4'hA,
        TX_LOW = 4'hB,
        TX_HIGH = 4'hC,
        RS_END = 4'hD
    } state_e;
endpackage

// >>> sim/i2c_seq_asserts.sv
// Purpose: Port checks for the two-wire master sequencer.
// Assumes: Pin enables high mean the wire is pulled low.
// Notes: Baud value is tracked from register writes.
module i2c_seq_asserts
    import i2c_seq_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [i2c_seq_pkg::ADDR_W-1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic SCL_OUT,
    input wire logic SCL_OE,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic WAKE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] baud;
    logic [9:0] lo_run;
    logic [9:0] hi_run;
    logic en_seen;
    //--------------------------------------------------------------
    // Helper logic
    //--------------------------------------------------------------
    // Runs start saturated so a reset never fakes a short phase
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            baud <= BAUD_RESET;
            lo_run <= 10'h3FF;
            hi_run <= 10'h3FF;
            en_seen <= 1'b0;
        end
        else
        begin
            if (WR && ADDR == REG_BAUD)
                baud <= WDATA;
            if (WR && ADDR == REG_CTRL && WDATA[CTRL_EN])
                en_seen <= 1'b1;
            lo_run <= SCL_OE ? lo_run + 10'(lo_run != 10'h3FF) : 10'h000;
            hi_run <= !SCL_OE ? hi_run + 10'(hi_run != 10'h3FF) : 10'h000;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // Quiet and pulse checks on the outputs; each clock phase lasts at least one baud period
    chk_reset_quiet: assert property ($rose(RST_N) |->
        !SCL_OE && !SDA_OE && !WAKE && RDATA == 8'h00)
        else $error("outputs active right after reset");
    chk_off_quiet: assert property (!en_seen |-> !SCL_OE && !SDA_OE)
        else $error("pins driven while disabled");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data without read strobe");
    chk_wake_pulse: assert property (WAKE |=> !WAKE)
        else $error("wake longer than one cycle");
    chk_pins_low: assert property (!SCL_OUT && !SDA_OUT)
        else $error("driven pin level not low");
    chk_scl_high: assert property ($rose(SCL_OE) |->
        hi_run > {2'b00, baud})
        else $error("clock high phase too short");
    chk_scl_low: assert property ($fell(SCL_OE) |->
        lo_run > {2'b00, baud})
        else $error("clock low phase too short");
    chk_stop_gap: assert property ($fell(SDA_OE) && !SCL_OE |->
        hi_run > {2'b00, baud})
        else $error("data released too soon after clock");
    cover property ($fell(SDA_OE) && !SCL_OE);
    cover property ($rose(SDA_OE) && !SCL_OE);
    cover property (WAKE);
endmodule

// >>> sim/i2c_target_model.sv
// Purpose: Behavioural target on the far side of the two-wire bus.
// Assumes: Wire levels arrive resolved; drive means pull low.
// Notes: Stretches each clock low phase by four times stretch.
module i2c_target_model
(
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic nack,
    input wire logic [2:0] stretch,
    output logic scl_oe,
    output logic sda_oe,
    output logic [7:0] rx_byte,
    output int starts,
    output int stops
);
    timeunit 1ns;
    timeprecision 100ps;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    logic [3:0] bits = 4'h0;
    logic [4:0] hold = 5'h00;
    initial
    begin
        {scl_oe, sda_oe, rx_byte, starts, stops} = '0;
    end
    // Sampled on the system clock, as the block itself sees the wires
    always @(posedge clk)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda)
        begin
            bits <= 4'h0;
            starts <= starts + 1;
        end
        else if (scl && scl_q && !sda_q && sda)
        begin
            bits <= 4'h0;
            stops <= stops + 1;
        end
        else if (scl && !scl_q)
        begin
            if (bits < 4'h8)
                rx_byte <= {rx_byte[6:0], sda};
            bits <= bits + 4'h1;
        end
        else if (!scl && scl_q)
        begin
            hold <= {stretch, 2'b00};
            scl_oe <= stretch != 3'h0;
            sda_oe <= bits == 4'h8 && !nack;
            if (bits == 4'h9)
                bits <= 4'h0;
        end
        else if (hold != 5'h00)
        begin
            hold <= hold - 5'h01;
            scl_oe <= hold != 5'h01;
        end
    end
endmodule

// >>> sim/i2c_master_bus_sequencer_tb_top.sv
// Purpose: Self-checking bench for the two-wire master sequencer.
// Assumes: Target model answers on the far side of the wires.
// Notes: Random bytes, acks and stretches from a fixed seed.
module i2c_master_bus_sequencer_tb_top;
    import i2c_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, wr, rd, jam, nack, scl, sda;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rx, b, d;
    logic [2:0] stretch;
    logic scl_out, scl_oe_m, sda_out, sda_oe_m, wake, t_scl_oe, t_sda_oe;
    int starts, stops, wakes, bad_count, comparisons;
    integer seed;
    // Open-drain wires: any enable pulls low
    assign scl = !(scl_oe_m | t_scl_oe);
    assign sda = !(sda_oe_m | t_sda_oe | jam);
    i2c_master_bus_sequencer uut (.MCLK(mclk), .RST_N(rst_n),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe_m),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe_m), .WAKE(wake));
    i2c_target_model far (.clk(mclk), .scl(scl), .sda(sda), .nack(nack),
        .stretch(stretch), .scl_oe(t_scl_oe), .sda_oe(t_sda_oe),
        .rx_byte(rx), .starts(starts), .stops(stops));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Counted mid-cycle, where the pulse has settled
    always @(negedge mclk)
        if (wake === 1'b1)
            wakes++;
    //--------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------
    task automatic print_verdict();
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic st_is(input int n, input logic v);
        logic [7:0] s;
        reg_rd(REG_STATUS, s);
        chk({7'h00, s[n]}, {7'h00, v});
    endtask
    // Polls a status bit; a hang ends the run
    task automatic wait_st(input int n);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 4000 && s[n] !== 1'b1; i++)
            reg_rd(REG_STATUS, s);
        if (s[n] !== 1'b1)
        begin
            bad_count++;
            print_verdict();
        end
    endtask
    // Looks mid-cycle, then returns just after a rising edge
    task automatic wait_scl(input logic v);
        int i;
        i = 0;
        @(negedge mclk);
        while (i < 300 && scl_oe_m !== v)
        begin
            @(negedge mclk);
            i++;
        end
        if (scl_oe_m !== v)
        begin
            bad_count++;
            print_verdict();
        end
        @(posedge mclk);
    endtask
    //--------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------
    initial
    begin
        {rst_n, wr, rd, jam, nack, addr, wdata, stretch} = '0;
        {bad_count, comparisons, wakes} = '0;
        seed = 32'h2347;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        reg_wr(4'hF, 8'hFF);
        reg_wr(REG_BUF, 8'h55);
        reg_rd(REG_BAUD, d);
        chk(d, BAUD_RESET);
        st_is(ST_WRITE_COLLISION_FLAG, 1'b1);
        reg_wr(REG_STATUS, 8'h37);
        reg_wr(REG_CTRL, 8'h21);
        reg_wr(REG_BAUD, 8'h0E);
        reg_rd(REG_BAUD, d);
        chk(d, 8'h0E);
        // Restart with a second request and a buffer write while busy
        reg_wr(REG_CTRL, 8'h23);
        reg_wr(REG_CTRL, 8'h27);
        reg_wr(REG_BUF, 8'hAA);
        wait_st(ST_IRQ);
        st_is(ST_START, 1'b1);
        st_is(ST_STOP, 1'b0);
        st_is(ST_WRITE_COLLISION_FLAG, 1'b1);
        reg_rd(REG_CTRL, d);
        chk(d, 8'h21);
        chk({7'h00, sda_oe_m}, 8'h01);
        chk(8'(starts), 8'h01);
        reg_wr(REG_STATUS, 8'h37);
        // Bytes: address first, then random data with edge values
        for (int n = 0; n < 5; n++)
        begin
            b = 8'($random(seed));
            b[0] = n == 0 ? 1'b0 : b[0];
            b = n == 1 ? 8'hFF : n == 2 ? 8'h00 : b;
            nack <= 1'($random(seed));
            stretch <= 3'($random(seed));
            reg_wr(REG_BUF, b);
            reg_wr(REG_BUF, ~b);
            st_is(ST_BF, 1'b1);
            st_is(ST_WRITE_COLLISION_FLAG, 1'b1);
            reg_wr(REG_STATUS, 8'h04);
            wait_st(ST_IRQ);
            chk(rx, b);
            st_is(ST_BF, 1'b0);
            reg_rd(REG_RXACK, d);
            chk({7'h00, d[0]}, {7'h00, nack});
            chk({7'h00, scl_oe_m}, 8'h01);
            reg_wr(REG_STATUS, 8'h37);
        end
        chk(8'(wakes), 8'h05);
        // Acknowledge sequence with both values
        for (int v = 0; v < 2; v++)
        begin
            reg_wr(REG_CTRL, 8'h21 | 8'(v << 4));
            reg_wr(REG_CTRL, 8'h29 | 8'(v << 4));
            reg_wr(REG_BUF, 8'h3C);
            wait_st(ST_IRQ);
            chk({7'h00, rx[0]}, 8'(v));
            st_is(ST_WRITE_COLLISION_FLAG, 1'b1);
            reg_rd(REG_CTRL, d);
            chk({7'h00, d[CTRL_ACKSEQ]}, 8'h00);
            reg_wr(REG_STATUS, 8'h37);
        end
        // Stop with a buffer write during it
        reg_wr(REG_CTRL, 8'h25);
        reg_wr(REG_BUF, 8'h81);
        wait_st(ST_IRQ);
        st_is(ST_STOP, 1'b1);
        st_is(ST_WRITE_COLLISION_FLAG, 1'b1);
        reg_rd(REG_CTRL, d);
        chk(d, 8'h21);
        chk({6'h00, scl_oe_m, sda_oe_m}, 8'h00);
        chk(8'(stops), 8'h01);
        reg_wr(REG_STATUS, 8'h37);
        // Data held low as the clock rises during a restart; the target
        // stretches the low phase so the jam lands before the rise
        stretch <= 3'h7;
        reg_wr(REG_CTRL, 8'h23);
        wait_scl(1'b1);
        wait_scl(1'b0);
        jam <= 1'b1;
        wait_st(ST_BCOL);
        chk({6'h00, scl_oe_m, sda_oe_m}, 8'h00);
        reg_rd(REG_CTRL, d);
        chk(d, 8'h21);
        jam <= 1'b0;
        // Reset in mid-byte drops the pins and disables the port
        reg_wr(REG_BUF, 8'hC3);
        wait_scl(1'b1);
        repeat (20) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk({6'h00, scl_oe_m, sda_oe_m}, 8'h00);
        reg_rd(REG_CTRL, d);
        chk(d, 8'h00);
        print_verdict();
    end
endmodule
bind i2c_master_bus_sequencer i2c_seq_asserts chk_u (.MCLK(MCLK),
    .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .WAKE(WAKE));
